// file: design/chcs_pkg.sv
// What this block does
// - Memory mode: drive read data during output enable.
// - I/O mode: output enable reads only config space during I/O cycles.
// - Memory mode: ready high when idle, low busy.
// - Ready low until power-up or reset completes.
// - Reset held since power-up never sticks busy in PC modes.
// - I/O mode interrupt: pulse or level, active low.
// - Fixed-disk mode interrupt is active high.
// - Space select high common, low attribute memory.
// - Ignore DMA grant while no DMA active.
// - Reset input high resets card in PC modes.
// - Reset high from power-up gives one reset.
// - Soft-reset bit performs a card reset.
// - Fixed-disk mode reset input is active low.
`default_nettype none
package chcs_pkg;
  localparam int unsigned CHCS_CLOCK_MHZ = 100;
  localparam int unsigned CHCS_RESET_TIME_NS = 1000;
  localparam int unsigned CHCS_RESET_CYCLES = (CHCS_RESET_TIME_NS * CHCS_CLOCK_MHZ + 999) / 1000;
  localparam int unsigned CHCS_IRQ_PULSE_CYCLES = 4;
  localparam logic [15:0] CHCS_DATA_RESET = 16'h0000;
  typedef enum logic [2:0] {
    CHCS_BUSY = 3'h1,
    CHCS_READY = 3'h2,
    CHCS_HOLD = 3'h4
  } chcs_state_t;
endpackage
`default_nettype wire

// file: design/chcs_control.sv
`default_nettype none
module chcs_control
  import chcs_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = CHCS_RESET_CYCLES,
  parameter int unsigned PULSE_CYCLES = CHCS_IRQ_PULSE_CYCLES
) (
  input wire logic clock, // Internal clock.
  input wire logic rst_b, // Power-on reset, active low.
  input wire logic diskModeSelect_n, // Low selects fixed-disk mode.
  input wire logic ioConfigured, // Card configured for I/O operation.
  input wire logic levelIrqMode, // 1 level interrupt, 0 pulse.
  input wire logic resetPin, // Host reset pin level.
  input wire logic softReset, // Soft-reset bit from option register.
  input wire logic readEnable_n, // Host output-enable strobe.
  input wire logic spaceSelect_n, // High common, low attribute.
  input wire logic ioCycle, // Current cycle is an I/O cycle.
  input wire logic [15:0] commonData, // Common memory read data.
  input wire logic [15:0] attribData, // Info structure and config data.
  input wire logic irqEvent, // One-cycle interrupt event.
  input wire logic irqClear, // Clears a pending level interrupt.
  input wire logic dmaActive, // DMA operation in progress.
  input wire logic dmaGrant_n, // Host DMA grant.
  output logic [15:0] dataOut, // Read data.
  output logic dataOe, // High while card drives data.
  output logic ready, // Ready, low while busy.
  output logic cardInterrupt_n, // I/O mode interrupt.
  output logic diskInterrupt, // Fixed-disk mode interrupt.
  output logic dmaGrantSeen, // Qualified DMA grant.
  output logic fixedDiskMode, // Mode taken at reset release.
  output logic cardInReset // Internal reset in progress.
);
  chcs_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic mode_reg, mode_next;
  logic armed_reg, armed_next;
  logic prevRst_reg, prevRst_next;
  logic prevSoft_reg, prevSoft_next;
  logic [15:0] data_reg, data_next;
  logic oe_reg, oe_next;
  logic pend_reg, pend_next;
  logic [7:0] pulse_reg, pulse_next;
  logic irqN_reg, irqN_next;
  logic irqH_reg, irqH_next;
  logic grant_reg, grant_next;
  logic rstLevel, rstEdge, softEdge;

  always_comb begin
    // Fixed-disk reset is active low; PC modes active high.
    rstLevel = mode_reg ? !resetPin : resetPin;
    // Only a fresh assertion resets, so a pin held since power-up is ignored in PC modes.
    rstEdge = armed_reg && rstLevel && !prevRst_reg;
    softEdge = softReset && !prevSoft_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    armed_next = armed_reg;
    prevRst_next = rstLevel;
    prevSoft_next = softReset;
    unique case (state_reg)
      CHCS_BUSY: begin
        if (cnt_reg == 16'(RESET_CYCLES - 1)) begin
          state_next = CHCS_READY;
          mode_next = !diskModeSelect_n;
          armed_next = 1'b1;
          cnt_next = 16'h0000;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      CHCS_READY: begin
        if (rstEdge) begin
          state_next = CHCS_HOLD;
        end else if (softEdge) begin
          state_next = CHCS_BUSY;
        end
      end
      CHCS_HOLD: begin
        if (!rstLevel) begin
          state_next = CHCS_BUSY;
        end
      end
      default: state_next = CHCS_BUSY;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CHCS_BUSY;
      cnt_reg <= 16'h0000;
      mode_reg <= 1'b0;
      armed_reg <= 1'b0;
      prevRst_reg <= 1'b1;
      prevSoft_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      armed_reg <= armed_next;
      prevRst_reg <= prevRst_next;
      prevSoft_reg <= prevSoft_next;
    end
  end

  always_comb begin
    data_next = data_reg;
    oe_next = 1'b0;
    pend_next = pend_reg;
    pulse_next = pulse_reg;
    irqN_next = 1'b1;
    irqH_next = 1'b0;
    grant_next = 1'b0;
    if (state_reg == CHCS_READY && !readEnable_n && !mode_reg) begin
      if (ioCycle) begin
        oe_next = 1'b1;
        data_next = attribData;
      end else begin
        oe_next = 1'b1;
        data_next = spaceSelect_n ? commonData : attribData;
      end
    end
    // A new event wins over a clear in the same cycle.
    if (irqEvent) begin
      pend_next = 1'b1;
      pulse_next = 8'(PULSE_CYCLES);
    end else begin
      if (irqClear) begin
        pend_next = 1'b0;
      end
      if (pulse_reg != 8'h00) begin
        pulse_next = pulse_reg - 8'h01;
      end
    end
    if (state_reg != CHCS_READY) begin
      pend_next = 1'b0;
      pulse_next = 8'h00;
    end
    if (mode_reg) begin
      irqH_next = pend_next;
    end else if (ioConfigured) begin
      irqN_next = levelIrqMode ? !pend_next : (pulse_next == 8'h00);
    end
    grant_next = mode_reg && dmaActive && !dmaGrant_n;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_reg <= CHCS_DATA_RESET;
      oe_reg <= 1'b0;
      pend_reg <= 1'b0;
      pulse_reg <= 8'h00;
      irqN_reg <= 1'b1;
      irqH_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      oe_reg <= oe_next;
      pend_reg <= pend_next;
      pulse_reg <= pulse_next;
      irqN_reg <= irqN_next;
      irqH_reg <= irqH_next;
      grant_reg <= grant_next;
    end
  end

  logic ready_reg, inReset_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ready_reg <= 1'b0;
      inReset_reg <= 1'b1;
    end else begin
      ready_reg <= (state_next == CHCS_READY);
      inReset_reg <= (state_next != CHCS_READY);
    end
  end

  assign dataOut = data_reg;
  assign dataOe = oe_reg;
  assign ready = ready_reg;
  assign cardInterrupt_n = irqN_reg;
  assign diskInterrupt = irqH_reg;
  assign dmaGrantSeen = grant_reg;
  assign fixedDiskMode = mode_reg;
  assign cardInReset = inReset_reg;

  // Ready is registered from the next state, so it always matches the state register.
  // Both reset causes must hold ready low for at least two edges after they are taken.
  sequence s_reset_start;
    state_reg == CHCS_READY && rstEdge;
  endsequence
  sequence s_soft_start;
    state_reg == CHCS_READY && !rstEdge && softEdge;
  endsequence
  sequence s_busy_two;
    !ready ##1 !ready;
  endsequence

  a_ready_busy: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg != CHCS_READY) |-> !ready) else $error("ready high while busy");
  a_ready_idle: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_READY) |-> ready) else $error("ready low while idle");
  a_grant_ignored: assert property (@(posedge clock) disable iff (!rst_b)
    !dmaActive |=> !dmaGrantSeen) else $error("grant seen without dma");
  a_grant_taken: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_reg && dmaActive && !dmaGrant_n) |=> dmaGrantSeen) else $error("grant lost in dma");
  a_disk_irq_low: assert property (@(posedge clock) disable iff (!rst_b)
    !mode_reg |=> !diskInterrupt) else $error("disk irq outside disk mode");
  a_disk_irq_high: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_reg && state_reg == CHCS_READY && irqEvent) |=> diskInterrupt)
    else $error("disk irq not raised");
  a_irq_quiet: assert property (@(posedge clock) disable iff (!rst_b)
    (!mode_reg && !ioConfigured) |=> cardInterrupt_n) else $error("irq while unconfigured");
  a_irq_start: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_READY && !mode_reg && ioConfigured && irqEvent) |=> !cardInterrupt_n)
    else $error("io irq not asserted");
  a_held_reset: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_BUSY && cnt_reg == 16'(RESET_CYCLES - 1)) |=> ready)
    else $error("ready not raised after reset");
  a_hold_reset: assert property (@(posedge clock) disable iff (!rst_b)
    s_reset_start |=> s_busy_two) else $error("reset ignored");
  a_soft_reset: assert property (@(posedge clock) disable iff (!rst_b)
    s_soft_start |=> s_busy_two) else $error("soft reset ignored");
  a_io_read: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_READY && !mode_reg && !readEnable_n && ioCycle)
    |=> dataOe && dataOut == $past(attribData)) else $error("io read wrong");
  a_mem_read: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_READY && !mode_reg && !readEnable_n && !ioCycle && spaceSelect_n)
    |=> dataOe && dataOut == $past(commonData)) else $error("common read wrong");
  a_attr_read: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == CHCS_READY && !mode_reg && !readEnable_n && !ioCycle && !spaceSelect_n)
    |=> dataOe && dataOut == $past(attribData)) else $error("attribute read wrong");
  a_disk_no_read: assert property (@(posedge clock) disable iff (!rst_b)
    mode_reg |=> !dataOe) else $error("data driven in disk mode");
endmodule
`default_nettype wire

// file: tb/chcs_host_model.sv
`default_nettype none
module chcs_host_model (
  input wire logic ready, // Card ready.
  input wire logic wantRead, // Read wanted.
  input wire logic wantAttr, // Attribute space wanted.
  input wire logic wantIo, // I/O cycle wanted.
  input wire logic wantDisk, // Fixed-disk mode wanted.
  input wire logic dmaOn, // DMA running.
  input wire logic wantGrant, // Grant wanted.
  input wire logic rogue, // Grant with no DMA, on purpose.
  output logic readEnable_n, // Read strobe.
  output logic spaceSelect_n, // Space select.
  output logic ioCycle, // I/O cycle.
  output logic diskModeSelect_n, // Mode select.
  output logic dmaGrant_n // DMA grant.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reads wait for ready so no access lands during busy.
  assign readEnable_n = !(wantRead && ready);
  assign spaceSelect_n = !(wantAttr || wantIo);
  assign ioCycle = wantIo;
  assign diskModeSelect_n = !wantDisk;
  assign dmaGrant_n = !((wantGrant && dmaOn) || rogue);
endmodule
`default_nettype wire

// file: tb/test_chcs_control.sv
`default_nettype none
module test_chcs_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 5;
  localparam int PC = 3;
  logic clock = 0, rst_b = 0, rd = 0, at = 0, io = 0, dk = 0, dma = 0, gr = 0, rg = 0;
  logic ioConfigured = 1, levelIrqMode = 0, resetPin = 0, softReset = 0;
  logic irqEvent = 0, irqClear = 0, readEnable_n, spaceSelect_n, ioCycle;
  logic diskModeSelect_n, dmaGrant_n, dataOe, ready, cardInterrupt_n, diskInterrupt;
  logic dmaGrantSeen, fixedDiskMode, cardInReset;
  logic [15:0] dataOut;
  logic [17:0] rows [3] = '{{2'b00, 16'h1234}, {2'b10, 16'h5a5a}, {2'b01, 16'h5a5a}};
  int err_total = 0, total_checks = 0, n;
  always #5 clock = ~clock;
  chcs_host_model u_chcs_host_model (.ready(ready), .wantRead(rd), .wantAttr(at),
    .wantIo(io), .wantDisk(dk), .dmaOn(dma), .wantGrant(gr), .rogue(rg),
    .readEnable_n(readEnable_n), .spaceSelect_n(spaceSelect_n), .ioCycle(ioCycle),
    .diskModeSelect_n(diskModeSelect_n), .dmaGrant_n(dmaGrant_n));
  chcs_control #(.RESET_CYCLES(RC), .PULSE_CYCLES(PC)) u_chcs_control (.clock(clock),
    .rst_b(rst_b), .diskModeSelect_n(diskModeSelect_n), .ioConfigured(ioConfigured),
    .levelIrqMode(levelIrqMode), .resetPin(resetPin), .softReset(softReset),
    .readEnable_n(readEnable_n), .spaceSelect_n(spaceSelect_n), .ioCycle(ioCycle),
    .commonData(16'h1234), .attribData(16'h5a5a), .irqEvent(irqEvent),
    .irqClear(irqClear), .dmaActive(dma), .dmaGrant_n(dmaGrant_n), .dataOut(dataOut),
    .dataOe(dataOe), .ready(ready), .cardInterrupt_n(cardInterrupt_n),
    .diskInterrupt(diskInterrupt), .dmaGrantSeen(dmaGrantSeen),
    .fixedDiskMode(fixedDiskMode), .cardInReset(cardInReset));
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Bounded wait; a card stuck busy shows up as a mismatch.
  task automatic waitReady();
    n = 0;
    while (ready !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk(16'(n < 30), 16'h1);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
  initial begin
    tick(5);
    chk(16'(ready), 16'h0);
    chk(16'(cardInReset), 16'h1);
    rst_b = 1;
    waitReady();
    chk(16'(cardInReset), 16'h0);
    chk(16'(fixedDiskMode), 16'h0);
    foreach (rows[i]) begin
      {at, io} = rows[i][17:16];
      rd = 1;
      tick(2);
      chk(16'(dataOe), 16'h1);
      chk(dataOut, rows[i][15:0]);
      rd = 0;
      tick(2);
      chk(16'(dataOe), 16'h0);
    end
    {at, io} = 2'b00;
    pulse(irqEvent);
    n = 0;
    // Counting starts at the edge that ends the event, where the pulse already stands.
    repeat (10) begin
      n += 32'(cardInterrupt_n === 1'b0);
      tick(1);
    end
    chk(16'(n), 16'(PC));
    pulse(irqClear);
    levelIrqMode = 1;
    tick(2);
    chk(16'(cardInterrupt_n), 16'h1);
    pulse(irqEvent);
    tick(5);
    chk(16'(cardInterrupt_n), 16'h0);
    pulse(irqClear);
    tick(2);
    chk(16'(cardInterrupt_n), 16'h1);
    irqEvent = 1;
    irqClear = 1;
    tick(1);
    irqEvent = 0;
    irqClear = 0;
    tick(1);
    chk(16'(cardInterrupt_n), 16'h0);
    pulse(irqClear);
    ioConfigured = 0;
    pulse(irqEvent);
    tick(1);
    chk(16'(cardInterrupt_n), 16'h1);
    pulse(irqClear);
    ioConfigured = 1;
    resetPin = 1;
    tick(2);
    chk(16'(ready), 16'h0);
    resetPin = 0;
    waitReady();
    dk = 1;
    softReset = 1;
    tick(2);
    chk(16'(ready), 16'h0);
    // The pin is raised while busy, as fixed-disk mode reads it active low.
    resetPin = 1;
    softReset = 0;
    waitReady();
    chk(16'(fixedDiskMode), 16'h1);
    rd = 1;
    tick(2);
    chk(16'(dataOe), 16'h0);
    rd = 0;
    pulse(irqEvent);
    tick(1);
    chk(16'(diskInterrupt), 16'h1);
    rg = 1;
    tick(2);
    chk(16'(dmaGrantSeen), 16'h0);
    {rg, dma, gr} = 3'b011;
    tick(2);
    chk(16'(dmaGrantSeen), 16'h1);
    {dma, gr} = 2'b00;
    resetPin = 0;
    tick(2);
    chk(16'(ready), 16'h0);
    resetPin = 1;
    waitReady();
    rst_b = 0;
    dk = 0;
    tick(2);
    chk(16'(ready), 16'h0);
    chk(16'(cardInReset), 16'h1);
    chk(16'(fixedDiskMode), 16'h0);
    chk(16'(diskInterrupt), 16'h0);
    rst_b = 1;
    waitReady();
    tick(3);
    chk(16'(ready), 16'h1);
    chk(16'(fixedDiskMode), 16'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
